//--- shared/bcc_regs.svh
// Register offsets, field positions, encodings and reset values
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH
`define BCC_OFF_CTRL     8'h00
`define BCC_OFF_INSTR    8'h04
`define BCC_OFF_INSTR2   8'h08
`define BCC_OFF_PC       8'h0C
`define BCC_OFF_STATUS   8'h10
`define BCC_OFF_WREG     8'h14
`define BCC_OFF_BSR      8'h18
`define BCC_OFF_FSR2     8'h1C
`define BCC_OFF_SHADOW   8'h20
`define BCC_OFF_TOS      8'h24
`define BCC_OFF_STKPTR   8'h28
`define BCC_OFF_ENGSTAT  8'h2C
`define BCC_OFF_DADDR    8'h30
`define BCC_OFF_DDATA    8'h34
`define BCC_CTRL_EXT     0
`define BCC_ST_Z         2
`define BCC_ST_OV        3
`define BCC_ES_BUSY      0
`define BCC_ES_DROP      1
`define BCC_ES_ILLEGAL   2
`define BCC_ES_OVF       3
`define BCC_ES_PHASE     4
`define BCC_SH_STATUS    8
`define BCC_SH_BSR       16
`define BCC_SP_FULL      8
`define BCC_HI_BOV       8'hE4
`define BCC_HI_BZ        8'hE0
`define BCC_HI_CALL      7'h76
`define BCC_HI_CLEAR_FILE_REGISTER      7'h35
`define BCC_PFX_CALL2    4'hF
`define BCC_S_BIT        8
`define BCC_A_BIT        8
`define BCC_PC_STEP      21'h000002
`define BCC_ACC_LIMIT    8'h5F
`define BCC_CLR_VALUE    8'h00
`define BCC_RST_PC       21'h000000
`define BCC_RST_FLAGS    5'h00
`define BCC_RST_BYTE     8'h00
`endif

//--- shared/bcc_pkg.sv
// Types shared by the instruction engine modules
package bcc_pkg;
  typedef enum logic [4:0] {
    BCC_PH_IDLE = 5'h01,
    BCC_PH_Q1   = 5'h02,
    BCC_PH_Q2   = 5'h04,
    BCC_PH_Q3   = 5'h08,
    BCC_PH_Q4   = 5'h10
  } bcc_phase_t;
  typedef enum logic [4:0] {
    BCC_OP_NOP  = 5'h01,
    BCC_OP_BOV  = 5'h02,
    BCC_OP_BZ   = 5'h04,
    BCC_OP_CALL = 5'h08,
    BCC_OP_CLEAR_FILE_REGISTER = 5'h10
  } bcc_op_t;
endpackage : bcc_pkg

//--- shared/bcc_stack_if.sv
// Return stack port bundle between engine and stack
`timescale 1ns/10ps
`default_nettype none
interface bcc_stack_if #(
  parameter int AW = 21,
  parameter int PW = 5
);
  logic          push;
  logic          pop;
  logic [AW-1:0] push_data;
  logic [AW-1:0] top_of_return_stack;
  logic [PW-1:0] ptr;
  logic          full;
  logic          ovf;
  modport owner (output push, pop, push_data, input top_of_return_stack, ptr, full, ovf);
  modport stack (input push, pop, push_data, output top_of_return_stack, ptr, full, ovf);
endinterface : bcc_stack_if
`default_nettype wire

//--- verilog/bcc_phase.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module bcc_phase #(
  parameter int CYC_W = 2
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 start,
  input  wire logic [CYC_W-1:0]     ncyc,
  output var  bcc_pkg::bcc_phase_t  phase,
  output var  logic [CYC_W-1:0]     cyc,
  output var  logic                 last
);
  bcc_pkg::bcc_phase_t ph_q;
  logic [CYC_W-1:0]    cyc_q;
  logic [CYC_W-1:0]    ncyc_q;

  if (CYC_W < 1) $error("CYC_W must be at least 1");

  assign phase = ph_q;
  assign cyc   = cyc_q;
  assign last  = (ph_q == bcc_pkg::BCC_PH_Q4) && (cyc_q == ncyc_q - CYC_W'(1));

  // Decode, read, process, write in strict order
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ph_q <= bcc_pkg::BCC_PH_IDLE;
    else
      case (ph_q)
        bcc_pkg::BCC_PH_IDLE: if (start) ph_q <= bcc_pkg::BCC_PH_Q1;
        bcc_pkg::BCC_PH_Q1:   ph_q <= bcc_pkg::BCC_PH_Q2;
        bcc_pkg::BCC_PH_Q2:   ph_q <= bcc_pkg::BCC_PH_Q3;
        bcc_pkg::BCC_PH_Q3:   ph_q <= bcc_pkg::BCC_PH_Q4;
        bcc_pkg::BCC_PH_Q4:   ph_q <= last ? bcc_pkg::BCC_PH_IDLE : bcc_pkg::BCC_PH_Q1;
        default:              ph_q <= bcc_pkg::BCC_PH_IDLE;
      endcase

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cyc_q  <= '0;
      ncyc_q <= '0;
    end
    else if (start && ph_q == bcc_pkg::BCC_PH_IDLE)
    begin
      cyc_q  <= '0;
      ncyc_q <= ncyc;
    end
    else if (ph_q == bcc_pkg::BCC_PH_Q4 && !last)
      cyc_q <= cyc_q + CYC_W'(1);
endmodule : bcc_phase
`default_nettype wire

//--- verilog/bcc_rstack.sv
// Return address stack with overflow report
`timescale 1ns/10ps
`default_nettype none
module bcc_rstack #(
  parameter int DEPTH = 31,
  parameter int AW    = 21,
  parameter int PW    = 5
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  bcc_stack_if.stack sif
);
  logic [AW-1:0] mem [DEPTH];
  logic [PW-1:0] ptr_q;
  logic          ovf_q;

  if (DEPTH < 1 || DEPTH >= (1 << PW)) $error("DEPTH does not fit PW");

  assign sif.ptr  = ptr_q;
  assign sif.full = (ptr_q == PW'(DEPTH));
  assign sif.top_of_return_stack  = (ptr_q == '0) ? '0 : mem[ptr_q - PW'(1)];
  assign sif.ovf  = ovf_q;

  // A full stack refuses the push and reports it instead of wrapping
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ptr_q <= '0;
      ovf_q <= 1'b0;
    end
    else
    begin
      ovf_q <= sif.push && sif.full;
      if (sif.push && !sif.full)
        ptr_q <= ptr_q + PW'(1);
      else if (sif.pop && ptr_q != '0)
        ptr_q <= ptr_q - PW'(1);
    end

  always_ff @(posedge clk)
    if (sif.push && !sif.full)
      mem[ptr_q] <= sif.push_data;
endmodule : bcc_rstack
`default_nettype wire

//--- verilog/bcc_exec.sv
// AHB-Lite instruction engine for branch, call and clear-register instructions
`timescale 1ns/10ps
`default_nettype none
`include "bcc_regs.svh"
module bcc_exec #(
  parameter int BANK_W    = 4,
  parameter int STK_DEPTH = 31,
  parameter int STK_PW    = 5
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic        busy
);
  localparam int PC_W    = 21;
  localparam int DATA_AW = BANK_W + 8;

  if (BANK_W < 1 || BANK_W > 8) $error("BANK_W out of range");

  logic [7:0]              dmem [1 << DATA_AW];
  logic                    ext_en_q;
  logic [15:0]             ir_q;
  logic [15:0]             ir2_q;
  logic [PC_W-1:0]         pc_q;
  logic [PC_W-1:0]         tgt_q;
  logic [4:0]              flags_q;
  logic [7:0]              wreg_q;
  logic [7:0]              lit_q;
  logic [7:0]              res_q;
  logic [7:0]              w_s_q;
  logic [4:0]              status_s_q;
  logic [BANK_W-1:0]       bsr_q;
  logic [BANK_W-1:0]       bsr_s_q;
  logic [DATA_AW-1:0]      fsr2_q;
  logic [DATA_AW-1:0]      daddr_q;
  logic [DATA_AW-1:0]      ea_q;
  logic                    drop_q;
  logic                    illegal_q;
  logic                    ovf_q;
  logic                    busy_q;
  logic                    taken_q;
  bcc_pkg::bcc_op_t        op_q;
  bcc_pkg::bcc_op_t        op_d;
  logic                    taken_d;
  logic [1:0]              ncyc_d;
  bcc_pkg::bcc_phase_t     phase;
  logic [1:0]              cyc;
  logic                    last;
  logic                    wr_pend_q;
  logic [7:0]              waddr_q;
  logic [31:0]             hrdata_q;
  logic [31:0]             rdata_d;
  logic                    hreadyout_q;
  logic                    hresp_q;
  logic                    bus_take;
  logic                    hi_ok;
  logic                    launch;
  logic                    ex0;
  logic [DATA_AW-1:0]      ea_d;

  bcc_stack_if #(.AW(PC_W), .PW(STK_PW)) sif ();

  function automatic logic hit(input logic [7:0] off);
    hit = wr_pend_q && (waddr_q == off);
  endfunction : hit

  function automatic logic in_phase(input bcc_pkg::bcc_phase_t p, input bcc_pkg::bcc_op_t o);
    in_phase = ex0 && (phase == p) && (op_q == o);
  endfunction : in_phase

  function automatic bcc_pkg::bcc_op_t op_of(input logic [15:0] w1, input logic [15:0] w2);
    if (w1[15:8] == `BCC_HI_BOV)
      op_of = bcc_pkg::BCC_OP_BOV;
    else if (w1[15:8] == `BCC_HI_BZ)
      op_of = bcc_pkg::BCC_OP_BZ;
    else if (w1[15:9] == `BCC_HI_CALL && w2[15:12] == `BCC_PFX_CALL2)
      op_of = bcc_pkg::BCC_OP_CALL;
    else if (w1[15:9] == `BCC_HI_CLEAR_FILE_REGISTER)
      op_of = bcc_pkg::BCC_OP_CLEAR_FILE_REGISTER;
    else
      op_of = bcc_pkg::BCC_OP_NOP;
  endfunction : op_of

  // Bank selection for file register operands
  function automatic logic [DATA_AW-1:0] bank_addr(input logic a, input logic [7:0] f);
    if (a)
      bank_addr = {bsr_q, f};
    else if (ext_en_q && f <= `BCC_ACC_LIMIT)
      bank_addr = fsr2_q + DATA_AW'(f);
    else if (f <= `BCC_ACC_LIMIT)
      bank_addr = {{BANK_W{1'b0}}, f};
    else
      bank_addr = {{BANK_W{1'b1}}, f};
  endfunction : bank_addr

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign busy      = busy_q;

  assign bus_take = hsel && htrans[1] && hready;
  assign hi_ok    = (haddr[31:8] == '0);
  // Launch is refused while busy rather than stalled, so the bus never waits
  assign launch   = hit(`BCC_OFF_INSTR) && !busy_q;
  assign op_d     = op_of(hwdata[15:0], ir2_q);
  assign ex0      = (cyc == 2'h0);
  assign ea_d     = bank_addr(ir_q[`BCC_A_BIT], ir_q[7:0]);

  // Flags are sampled at launch; nothing else can change them mid-instruction
  always_comb
  begin
    taken_d = 1'b0;
    if (op_d == bcc_pkg::BCC_OP_BOV)
      taken_d = flags_q[`BCC_ST_OV];
    else if (op_d == bcc_pkg::BCC_OP_BZ)
      taken_d = flags_q[`BCC_ST_Z];
    ncyc_d = 2'h1;
    if (taken_d || op_d == bcc_pkg::BCC_OP_CALL)
      ncyc_d = 2'h2;
  end

  bcc_phase #(.CYC_W(2)) u_phase (
    .clk   (hclk),
    .rst_n (hresetn),
    .start (launch),
    .ncyc  (ncyc_d),
    .phase (phase),
    .cyc   (cyc),
    .last  (last)
  );

  bcc_rstack #(.DEPTH(STK_DEPTH), .AW(PC_W), .PW(STK_PW)) u_stack (
    .clk   (hclk),
    .rst_n (hresetn),
    .sif   (sif)
  );

  // Return address is the call address plus 4
  assign sif.push      = in_phase(bcc_pkg::BCC_PH_Q3, bcc_pkg::BCC_OP_CALL);
  assign sif.push_data = pc_q + `BCC_PC_STEP;
  assign sif.pop       = hit(`BCC_OFF_TOS) && !busy_q;

  // Bus address phase capture; the slave answers with no wait state
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_q   <= 1'b0;
      waddr_q     <= `BCC_RST_BYTE;
      hrdata_q    <= '0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
    else
    begin
      wr_pend_q   <= bus_take && hwrite && hi_ok;
      waddr_q     <= haddr[7:0];
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (bus_take && !hwrite)
        hrdata_q <= hi_ok ? rdata_d : '0;
    end

  always_comb
  begin
    rdata_d = '0;
    case (haddr[7:0])
      `BCC_OFF_CTRL:    rdata_d[`BCC_CTRL_EXT] = ext_en_q;
      `BCC_OFF_INSTR:   rdata_d[15:0] = ir_q;
      `BCC_OFF_INSTR2:  rdata_d[15:0] = ir2_q;
      `BCC_OFF_PC:      rdata_d[PC_W-1:0] = pc_q;
      `BCC_OFF_STATUS:  rdata_d[4:0] = flags_q;
      `BCC_OFF_WREG:    rdata_d[7:0] = wreg_q;
      `BCC_OFF_BSR:     rdata_d[BANK_W-1:0] = bsr_q;
      `BCC_OFF_FSR2:    rdata_d[DATA_AW-1:0] = fsr2_q;
      `BCC_OFF_SHADOW:
      begin
        rdata_d[7:0] = w_s_q;
        rdata_d[`BCC_SH_STATUS +: 5] = status_s_q;
        rdata_d[`BCC_SH_BSR +: BANK_W] = bsr_s_q;
      end
      `BCC_OFF_TOS:     rdata_d[PC_W-1:0] = sif.top_of_return_stack;
      `BCC_OFF_STKPTR:
      begin
        rdata_d[STK_PW-1:0] = sif.ptr;
        rdata_d[`BCC_SP_FULL] = sif.full;
      end
      `BCC_OFF_ENGSTAT:
      begin
        rdata_d[`BCC_ES_BUSY] = busy_q;
        rdata_d[`BCC_ES_DROP] = drop_q;
        rdata_d[`BCC_ES_ILLEGAL] = illegal_q;
        rdata_d[`BCC_ES_OVF] = ovf_q;
        rdata_d[`BCC_ES_PHASE +: 5] = phase;
      end
      `BCC_OFF_DADDR:   rdata_d[DATA_AW-1:0] = daddr_q;
      `BCC_OFF_DDATA:   rdata_d[7:0] = dmem[daddr_q];
      default:          rdata_d = '0;
    endcase
  end

  // Plain configuration registers
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ext_en_q <= 1'b0;
      ir2_q    <= '0;
      fsr2_q   <= '0;
      daddr_q  <= '0;
    end
    else
    begin
      if (hit(`BCC_OFF_CTRL))
        ext_en_q <= hwdata[`BCC_CTRL_EXT];
      if (hit(`BCC_OFF_INSTR2) && !busy_q)
        ir2_q <= hwdata[15:0];
      if (hit(`BCC_OFF_FSR2))
        fsr2_q <= hwdata[DATA_AW-1:0];
      if (hit(`BCC_OFF_DADDR))
        daddr_q <= hwdata[DATA_AW-1:0];
    end

  // Instruction latch and run state
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ir_q    <= '0;
      op_q    <= bcc_pkg::BCC_OP_NOP;
      taken_q <= 1'b0;
      busy_q  <= 1'b0;
    end
    else if (launch)
    begin
      ir_q    <= hwdata[15:0];
      op_q    <= op_d;
      taken_q <= taken_d;
      busy_q  <= 1'b1;
    end
    else if (last)
      busy_q <= 1'b0;

  // Sticky engine events; a new event beats a write-one clear
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      drop_q    <= 1'b0;
      illegal_q <= 1'b0;
      ovf_q     <= 1'b0;
    end
    else
    begin
      drop_q    <= (hit(`BCC_OFF_INSTR) && busy_q)
                   || (drop_q && !(hit(`BCC_OFF_ENGSTAT) && hwdata[`BCC_ES_DROP]));
      illegal_q <= (launch && op_d == bcc_pkg::BCC_OP_NOP)
                   || (illegal_q && !(hit(`BCC_OFF_ENGSTAT) && hwdata[`BCC_ES_ILLEGAL]));
      ovf_q     <= sif.ovf
                   || (ovf_q && !(hit(`BCC_OFF_ENGSTAT) && hwdata[`BCC_ES_OVF]));
    end

  // Operand latch in phase two, result in phase three
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      lit_q <= `BCC_RST_BYTE;
      ea_q  <= '0;
      res_q <= `BCC_RST_BYTE;
      tgt_q <= `BCC_RST_PC;
    end
    else if (ex0 && phase == bcc_pkg::BCC_PH_Q2)
    begin
      lit_q <= ir_q[7:0];
      ea_q  <= ea_d;
    end
    else if (ex0 && phase == bcc_pkg::BCC_PH_Q3)
    begin
      tgt_q <= pc_q + {{(PC_W-9){lit_q[7]}}, lit_q, 1'b0};
      res_q <= `BCC_CLR_VALUE;
    end

  // Program counter: fetch step in phase one, redirect only in phase four
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pc_q <= `BCC_RST_PC;
    else if (ex0 && phase == bcc_pkg::BCC_PH_Q1)
      pc_q <= pc_q + `BCC_PC_STEP;
    else if (in_phase(bcc_pkg::BCC_PH_Q3, bcc_pkg::BCC_OP_CALL))
      pc_q <= pc_q + `BCC_PC_STEP;
    else if (ex0 && phase == bcc_pkg::BCC_PH_Q4 && taken_q)
      pc_q <= tgt_q;
    else if (in_phase(bcc_pkg::BCC_PH_Q4, bcc_pkg::BCC_OP_CALL))
      pc_q <= {ir2_q[11:0], lit_q, 1'b0};
    else if (hit(`BCC_OFF_PC) && !busy_q)
      pc_q <= {hwdata[PC_W-1:1], 1'b0};

  // Flags: of the instructions only clear touches them, and only zero; software writes them while idle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      flags_q <= `BCC_RST_FLAGS;
    else if (in_phase(bcc_pkg::BCC_PH_Q4, bcc_pkg::BCC_OP_CLEAR_FILE_REGISTER))
      flags_q[`BCC_ST_Z] <= 1'b1;
    else if (hit(`BCC_OFF_STATUS) && !busy_q)
      flags_q <= hwdata[4:0];

  // Working and bank select registers, writable only while idle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wreg_q <= `BCC_RST_BYTE;
      bsr_q  <= '0;
    end
    else if (!busy_q)
    begin
      if (hit(`BCC_OFF_WREG))
        wreg_q <= hwdata[7:0];
      if (hit(`BCC_OFF_BSR))
        bsr_q <= hwdata[BANK_W-1:0];
    end

  // Shadow copies alongside the stack push
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      w_s_q      <= `BCC_RST_BYTE;
      status_s_q <= `BCC_RST_FLAGS;
      bsr_s_q    <= '0;
    end
    else if (in_phase(bcc_pkg::BCC_PH_Q3, bcc_pkg::BCC_OP_CALL) && ir_q[`BCC_S_BIT])
    begin
      w_s_q      <= wreg_q;
      status_s_q <= flags_q;
      bsr_s_q    <= bsr_q;
    end

  // Data memory; the engine's write wins a same-cycle collision with software
  always_ff @(posedge hclk)
    if (in_phase(bcc_pkg::BCC_PH_Q4, bcc_pkg::BCC_OP_CLEAR_FILE_REGISTER))
      dmem[ea_q] <= res_q;
    else if (hit(`BCC_OFF_DDATA))
      dmem[daddr_q] <= hwdata[7:0];
endmodule : bcc_exec
`default_nettype wire

//--- verif/bcc_exec_props.sv
// Checker for busy timing of the instruction engine
`timescale 1ns/10ps
`default_nettype none
`include "bcc_regs.svh"
module bcc_exec_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        busy
);
  logic        take;
  logic        go;
  logic        br;
  logic        dp1_q;
  logic        dp2_q;
  logic [15:0] i2_q;
  logic [3:0]  run_q;
  assign take = hsel && htrans[1] && hready && hwrite && (haddr[31:8] == 24'h000000);
  assign go   = dp1_q && !busy;
  assign br   = (hwdata[15:8] == `BCC_HI_BOV) || (hwdata[15:8] == `BCC_HI_BZ);
  // Second word kept here, since the length of a call depends on its prefix
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp1_q <= 1'b0;
      dp2_q <= 1'b0;
      i2_q  <= 16'h0000;
      run_q <= 4'h0;
    end
    else
    begin
      dp1_q <= take && (haddr[7:0] == `BCC_OFF_INSTR);
      dp2_q <= take && (haddr[7:0] == `BCC_OFF_INSTR2);
      i2_q  <= (dp2_q && !busy) ? hwdata[15:0] : i2_q;
      run_q <= busy ? run_q + 4'h1 : 4'h0;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_LAUNCH: assert property (go |=> busy)
    else $error("accepted word did not raise busy");
  AST_NO_SPURIOUS: assert property ($rose(busy) |-> $past(go))
    else $error("busy rose without an accepted word");
  AST_RUN_LEN: assert property ($fell(busy) |-> run_q == 4'h4 || run_q == 4'h8)
    else $error("busy run is not four or eight cycles");
  AST_CLEAR_ONE: assert property (go && hwdata[15:9] == `BCC_HI_CLEAR_FILE_REGISTER |=> busy[*4] ##1 !busy)
    else $error("clear did not finish in one cycle");
  AST_BRANCH: assert property (go && br |=> busy[*4] ##1 (!busy or busy[*4] ##1 !busy))
    else $error("branch length is wrong");
  AST_CALL_TWO: assert property (go && hwdata[15:9] == `BCC_HI_CALL
    && i2_q[15:12] == `BCC_PFX_CALL2 |=> busy[*8] ##1 !busy)
    else $error("call did not take two cycles");
  AST_CALL_BAD: assert property (go && hwdata[15:9] == `BCC_HI_CALL
    && i2_q[15:12] != `BCC_PFX_CALL2 |=> busy[*4] ##1 !busy)
    else $error("call without second word prefix not one cycle");
  AST_OTHER_ONE: assert property (go && !br && hwdata[15:9] != `BCC_HI_CALL
    && hwdata[15:9] != `BCC_HI_CLEAR_FILE_REGISTER |=> busy[*4] ##1 !busy)
    else $error("unknown word did not finish in one cycle");
  COV_CALL: cover property (go && hwdata[15:9] == `BCC_HI_CALL);
  COV_LONG: cover property ($fell(busy) && run_q == 4'h8);
  COV_DROP: cover property (dp1_q && busy);
endmodule : bcc_exec_props
bind bcc_exec bcc_exec_props i_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .busy(busy)
);
`default_nettype wire

//--- verif/bcc_prog_model.sv
// Program memory model holding instruction words
`timescale 1ns/10ps
`default_nettype none
module bcc_prog_model;
  logic [15:0] mem [logic [20:0]];
  // Unwritten words read as erased memory rather than a stale value
  function automatic logic [15:0] fetch(input logic [20:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : fetch
  task automatic load(input logic [20:0] a, input logic [15:0] w);
    mem[a] = w;
  endtask : load
endmodule : bcc_prog_model
`default_nettype wire

//--- verif/tb_top.sv
// Random and corner bench for the instruction engine
`timescale 1ns/10ps
`default_nettype none
`include "bcc_regs.svh"
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module tb_top;
  logic        hclk       = 1'b0;
  logic        hresetn    = 1'b0;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h00000000;
  logic [1:0]  htrans     = 2'b00;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h00000000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        busy;
  logic [31:0] rd;
  logic [15:0] seed       = 16'h0047;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          n_cyc      = 0;
  always #50 hclk = ~hclk;
  bcc_prog_model i_prog ();
  bcc_exec i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy)
  );
  function automatic logic [15:0] lfsr();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : lfsr
  // Branch condition from the opcode and the flags written before launch
  function automatic logic exp_tk(input logic [15:0] w, input logic [4:0] st);
    return (w[15:8] == `BCC_HI_BOV) ? st[`BCC_ST_OV] : st[`BCC_ST_Z];
  endfunction : exp_tk
  function automatic logic [20:0] exp_br(input logic [20:0] pc, input logic [15:0] w,
                                         input logic [4:0] st);
    return exp_tk(w, st) ? pc + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0} : pc + 21'h000002;
  endfunction : exp_br
  function automatic logic [11:0] exp_ea(input int c, input logic [3:0] b,
                                         input logic [11:0] x, input logic [7:0] f);
    case (c)
      0: return {b, f};
      1: return {4'h0, f};
      2: return {4'hF, f};
      default: return x + {4'h0, f};
    endcase
  endfunction : exp_ea
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic give_up();
    n_errors++;
    print_verdict();
  endtask : give_up
  // Waits for hready at an edge; a slave that never answers ends the run
  task automatic ready_edge();
    int k;
    for (k = 0; k < 40; k++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        break;
    end
    if (k >= 40)
      give_up();
  endtask : ready_edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    ready_edge();
    htrans <= 2'b00;
    hwdata <= wd;
    ready_edge();
    rd = hrdata;
  endtask : bus
  task automatic exec(input logic [15:0] w);
    int k;
    bus(1'b1, `BCC_OFF_INSTR, {16'h0000, w});
    #1;
    for (k = 0; k < 20 && busy !== 1'b0; k++)
    begin
      @(posedge hclk);
      #1;
    end
    n_cyc = k;
    if (k >= 20)
      give_up();
    @(posedge hclk);
  endtask : exec
  initial
  begin : main
    logic [15:0] v;
    logic [20:0] pc;
    logic [19:0] k;
    logic [7:0]  f;
    logic [4:0]  st;
    logic [11:0] ea;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `BCC_OFF_ENGSTAT, 32'h0);
    `CHK("idle_phase", 32'h00000010, rd);
    bus(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped", 32'h0, rd);
    `CHK("resp_ready", 2'b10, {hreadyout, hresp});
    for (int i = 0; i < 16; i++)
    begin
      v  = lfsr();
      pc = {v[4:0], lfsr()} & 21'h1FFFFE;
      st = v[9:5];
      f  = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : v[15:8];
      i_prog.load(pc, {(i % 2 == 1) ? `BCC_HI_BOV : `BCC_HI_BZ, f});
      bus(1'b1, `BCC_OFF_STATUS, {27'h0, st});
      bus(1'b1, `BCC_OFF_PC, {11'h0, pc});
      exec(i_prog.fetch(pc));
      bus(1'b0, `BCC_OFF_PC, 32'h0);
      `CHK("branch_pc", exp_br(pc, i_prog.fetch(pc), st), rd);
      bus(1'b0, `BCC_OFF_STATUS, 32'h0);
      `CHK("branch_flags", st, rd);
      `CHK("branch_len", exp_tk(i_prog.fetch(pc), st) ? 8 : 4, n_cyc);
    end
    for (int i = 0; i < 2; i++)
    begin
      v  = lfsr();
      k  = {v[3:0], lfsr()};
      pc = {v[8:4], lfsr()} & 21'h1FFFFE;
      i_prog.load(pc, {`BCC_HI_CALL, i[0], k[7:0]});
      i_prog.load(pc + 21'h000002, {`BCC_PFX_CALL2, k[19:8]});
      bus(1'b1, `BCC_OFF_WREG, {24'h0, v[15:8]});
      bus(1'b1, `BCC_OFF_STATUS, {27'h0, v[13:9]});
      bus(1'b1, `BCC_OFF_BSR, {28'h0, v[7:4]});
      bus(1'b1, `BCC_OFF_PC, {11'h0, pc});
      bus(1'b1, `BCC_OFF_INSTR2, {16'h0, i_prog.fetch(pc + 21'h000002)});
      exec(i_prog.fetch(pc));
      bus(1'b0, `BCC_OFF_PC, 32'h0);
      `CHK("call_pc", {k, 1'b0}, rd);
      `CHK("call_len", 8, n_cyc);
      bus(1'b0, `BCC_OFF_TOS, 32'h0);
      `CHK("call_tos", pc + 21'h000004, rd);
      bus(1'b0, `BCC_OFF_SHADOW, 32'h0);
      `CHK("call_shadow", i ? {12'h0, v[7:4], 3'h0, v[13:9], v[15:8]} : 32'h0, rd);
      bus(1'b0, `BCC_OFF_STKPTR, 32'h0);
      `CHK("call_sp", i + 1, rd[4:0]);
    end
    bus(1'b1, `BCC_OFF_TOS, 32'h0);
    bus(1'b0, `BCC_OFF_STKPTR, 32'h0);
    `CHK("pop_sp", 1, rd[4:0]);
    bus(1'b1, `BCC_OFF_INSTR2, 32'h00000123);
    bus(1'b1, `BCC_OFF_PC, 32'h00000100);
    exec({`BCC_HI_CALL, 1'b0, 8'h40});
    bus(1'b0, `BCC_OFF_PC, 32'h0);
    `CHK("bad_call_pc", 32'h00000102, rd);
    for (int i = 0; i < 4; i++)
    begin
      v  = lfsr();
      f  = (i == 1) ? 8'h5F : (i == 2) ? 8'h60 : (i == 3) ? {2'h0, v[5:0]} : v[7:0];
      st = {v[12:11], 1'b0, v[9:8]};
      ea = exp_ea(i, v[11:8], v[15:4], f);
      bus(1'b1, `BCC_OFF_CTRL, (i == 3) ? 32'h1 : 32'h0);
      bus(1'b1, `BCC_OFF_BSR, {28'h0, v[11:8]});
      bus(1'b1, `BCC_OFF_FSR2, {20'h0, v[15:4]});
      bus(1'b1, `BCC_OFF_STATUS, {27'h0, st});
      bus(1'b1, `BCC_OFF_DADDR, {20'h0, ea});
      bus(1'b1, `BCC_OFF_DDATA, 32'h000000A5);
      exec({`BCC_HI_CLEAR_FILE_REGISTER, i == 0, f});
      bus(1'b0, `BCC_OFF_DDATA, 32'h0);
      `CHK("clear_data", 32'h0, rd);
      bus(1'b0, `BCC_OFF_STATUS, 32'h0);
      `CHK("clear_flags", st | 5'h04, rd);
      `CHK("clear_len", 4, n_cyc);
    end
    bus(1'b1, `BCC_OFF_INSTR, 32'h0);
    exec(16'h0000);
    bus(1'b0, `BCC_OFF_ENGSTAT, 32'h0);
    `CHK("drop_flag", 32'h2, rd & 32'h2);
    `CHK("illegal_flag", 32'h4, rd & 32'h4);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
